//--- rtl/gpio_regs.svh
`ifndef GPIO_REGS_SVH
`define GPIO_REGS_SVH

// ***************************************************************
// Register map layout
// ***************************************************************
// Each port owns a block of four words; the port index sits above it.
`define PORT_SEL_LSB 4
`define PORT_SEL_MSB 7
`define REG_SEL_LSB 2
`define REG_SEL_MSB 3
// Address bits above the port index must be zero.
`define ADDR_TOP_LSB 8
`define ADDR_TOP_MSB 11
`define ADDR_W 12
`define ADDR_SPACE_PORTS 16

// ***************************************************************
// Reset values
// ***************************************************************
`define LATCH_RESET 8'h00
`define DIR_RESET 8'hFF
`define FMODE_RESET 8'h00
`define ODRAIN_RESET 8'h00

// ***************************************************************
// Bit encodings
// ***************************************************************
`define DIR_INPUT 1'b1
`define FMODE_ALT 1'b1
`define ODRAIN_ON 1'b1

`endif

//--- rtl/gpio_pkg.sv
package gpio_pkg;

    // Register within a port block.
    typedef enum logic [1:0] {
        REG_DATA = 2'b00,
        REG_DIR = 2'b01,
        REG_FMODE = 2'b10,
        REG_ODRAIN = 2'b11
    } reg_sel_t;

    // APB request as seen by the slave.
    typedef struct packed {
        logic sel;
        logic enable;
        logic write;
        logic [11:0] addr;
        logic [31:0] wdata;
        logic [3:0] strb;
    } apb_req_t;

    // Configuration of one pin.
    typedef struct packed {
        logic latch;
        logic dir;
        logic fmode;
        logic odrain;
    } pin_cfg_t;

endpackage : gpio_pkg

//--- rtl/general_purpose_port_control.sv
`timescale 1ns/1ps
`include "gpio_regs.svh"
// Operation
// - Data register: output latch plus pin sampling
// - One bit per pin, individually accessible
// - Direction bit: 0 output, 1 input
// - Function-mode bit: 0 port, 1 alternate
// - Port output: write latch, latch drives pin
// - Port output: read returns latch
// - Port input: write latch, pin unchanged
// - Input direction: read returns pin level
// - Alternate mode: function drives pin, latch stored
// - Alternate output function: read function output
// - Alternate input function, output direction: read latch
// - Latch holds value until next write
// - 16 input-only pins, 112 bidirectional
// - Open-drain only effective in output direction
module general_purpose_port_control
    import gpio_pkg::*;
#(
    parameter int PORT_W = 8,
    parameter int IO_PORTS = 14,
    parameter int IN_PORTS = 2
)
(
    input wire logic pclk, // APB clock, 100 MHz
    input wire logic presetn, // Asynchronous reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction, high for write
    input wire logic [11:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    input wire logic [3:0] pstrb, // APB byte strobes
    output logic pready, // APB ready
    output logic [31:0] prdata, // APB read data
    output logic pslverr, // APB error on unmapped address
    input wire logic [(IO_PORTS+IN_PORTS)*PORT_W-1:0] pin_in, // Pin levels
    output logic [IO_PORTS*PORT_W-1:0] pin_out, // Pin drive value
    output logic [IO_PORTS*PORT_W-1:0] pin_oe, // Pin drive enable
    input wire logic [IO_PORTS*PORT_W-1:0] alt_out, // Peripheral output
    input wire logic [IO_PORTS*PORT_W-1:0] alt_is_out, // Function is output
    output logic [(IO_PORTS+IN_PORTS)*PORT_W-1:0] alt_in, // Pin to peripheral
    output logic [(IO_PORTS+IN_PORTS)*PORT_W-1:0] alt_sel // Pin in alt mode
);

    localparam int NPORT = IO_PORTS + IN_PORTS;
    localparam int NPIN = NPORT * PORT_W;
    localparam int NIO = IO_PORTS * PORT_W;

    // ***************************************************************
    // Elaboration checks
    // ***************************************************************
    // The register fields are one byte wide, and the port index field
    // has room for a fixed number of ports.
    if (PORT_W != 8)
    begin : g_bad_width
        $error("PORT_W must be 8");
    end
    if (NPORT > `ADDR_SPACE_PORTS || IO_PORTS < 1)
    begin : g_bad_ports
        $error("port count out of range");
    end
    if (IN_PORTS < 0)
    begin : g_bad_inputs
        $error("IN_PORTS must not be negative");
    end

    // ***************************************************************
    // Functions
    // ***************************************************************
    // True when the address names an existing register word.
    function automatic logic addr_ok(input logic [11:0] a);
        logic [3:0] port;
        port = a[`PORT_SEL_MSB:`PORT_SEL_LSB];
        addr_ok = (a[`ADDR_TOP_MSB:`ADDR_TOP_LSB] == 4'h0)
            && (a[1:0] == 2'h0) && (int'(port) < NPORT);
    endfunction : addr_ok

    // Value software reads from one data bit.
    function automatic logic data_bit(input pin_cfg_t c, input logic pin,
                                      input logic aout, input logic aisout);
        if (c.dir == `DIR_INPUT)
            data_bit = pin;
        else if (c.fmode != `FMODE_ALT)
            data_bit = c.latch;
        else if (aisout)
            data_bit = aout;
        else
            data_bit = c.latch;
    endfunction : data_bit

    // ***************************************************************
    // Storage
    // ***************************************************************
    apb_req_t req;
    logic [NPIN-1:0] sync1_q;
    logic [NPIN-1:0] sync2_q;
    logic [PORT_W-1:0] latch_q [NPORT];
    logic [PORT_W-1:0] dir_q [NPORT];
    logic [PORT_W-1:0] fmode_q [NPORT];
    logic [PORT_W-1:0] odrain_q [NPORT];
    logic [NIO-1:0] pin_out_q;
    logic [NIO-1:0] pin_oe_q;
    logic [NIO-1:0] pin_out_d;
    logic [NIO-1:0] pin_oe_d;
    logic [31:0] prdata_q;
    logic [31:0] prdata_d;
    logic [3:0] port_idx;
    reg_sel_t reg_sel;
    logic hit;
    logic wr_en;

    assign req = '{sel: psel, enable: penable, write: pwrite, addr: paddr,
                   wdata: pwdata, strb: pstrb};
    assign port_idx = req.addr[`PORT_SEL_MSB:`PORT_SEL_LSB];
    assign reg_sel = reg_sel_t'(req.addr[`REG_SEL_MSB:`REG_SEL_LSB]);
    assign hit = addr_ok(req.addr);

    // ***************************************************************
    // APB slave
    // ***************************************************************
    // No wait state: read data is gathered in the setup cycle so that
    // it leaves a flip-flop in the access cycle.
    // An unmapped word is refused: pslverr rises and nothing changes.
    assign pready = req.sel && req.enable;
    assign pslverr = pready && !hit;
    assign prdata = prdata_q;
    assign wr_en = pready && req.write && hit && req.strb[0];

    // Read value of the addressed register, before it is captured.
    always_comb
    begin
        prdata_d = 32'h00000000;
        if (hit)
        begin
            for (int p = 0; p < NPORT; p++)
            begin
                if (int'(port_idx) == p)
                begin
                    case (reg_sel)
                        REG_DATA:
                        begin
                            for (int b = 0; b < PORT_W; b++)
                            begin
                                if (p < IO_PORTS)
                                    prdata_d[b] = data_bit(
                                        '{latch: latch_q[p][b],
                                          dir: dir_q[p][b],
                                          fmode: fmode_q[p][b],
                                          odrain: odrain_q[p][b]},
                                        sync2_q[p*PORT_W+b],
                                        alt_out[p*PORT_W+b],
                                        alt_is_out[p*PORT_W+b]);
                                else
                                    prdata_d[b] = sync2_q[p*PORT_W+b];
                            end
                        end
                        REG_DIR: prdata_d[PORT_W-1:0] = dir_q[p];
                        REG_FMODE: prdata_d[PORT_W-1:0] = fmode_q[p];
                        REG_ODRAIN: prdata_d[PORT_W-1:0] = odrain_q[p];
                        default: prdata_d = 32'h00000000;
                    endcase
                end
            end
        end
    end

    // Read data is captured in the setup cycle and held until the next read.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata_q <= 32'h00000000;
        else if (req.sel && !req.enable && !req.write)
            prdata_q <= prdata_d;
    end

    // ***************************************************************
    // Pin synchroniser
    // ***************************************************************
    // Pin levels are asynchronous. Only the second stage is read, by the
    // data read path and by the peripherals through alt_in.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync1_q <= '0;
            sync2_q <= '0;
        end
        else
        begin
            sync1_q <= pin_in;
            sync2_q <= sync1_q;
        end
    end

    assign alt_in = sync2_q;

    // ***************************************************************
    // Port registers
    // ***************************************************************
    // Output latch: it takes every data write whatever the direction and
    // mode, and is otherwise left alone.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int p = 0; p < NPORT; p++)
                latch_q[p] <= `LATCH_RESET;
        end
        else if (wr_en && reg_sel == REG_DATA)
        begin
            for (int p = 0; p < NPORT; p++)
            begin
                if (int'(port_idx) == p)
                    latch_q[p] <= req.wdata[PORT_W-1:0];
            end
        end
    end

    // Direction: input-only ports keep their reset value, all input.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int p = 0; p < NPORT; p++)
                dir_q[p] <= `DIR_RESET;
        end
        else if (wr_en && reg_sel == REG_DIR)
        begin
            for (int p = 0; p < IO_PORTS; p++)
            begin
                if (int'(port_idx) == p)
                    dir_q[p] <= req.wdata[PORT_W-1:0];
            end
        end
    end

    // Function mode: writable on every port, input-only ports included.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int p = 0; p < NPORT; p++)
                fmode_q[p] <= `FMODE_RESET;
        end
        else if (wr_en && reg_sel == REG_FMODE)
        begin
            for (int p = 0; p < NPORT; p++)
            begin
                if (int'(port_idx) == p)
                    fmode_q[p] <= req.wdata[PORT_W-1:0];
            end
        end
    end

    // Open drain: only ports with a driver keep the bit.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int p = 0; p < NPORT; p++)
                odrain_q[p] <= `ODRAIN_RESET;
        end
        else if (wr_en && reg_sel == REG_ODRAIN)
        begin
            for (int p = 0; p < IO_PORTS; p++)
            begin
                if (int'(port_idx) == p)
                    odrain_q[p] <= req.wdata[PORT_W-1:0];
            end
        end
    end

    // ***************************************************************
    // Pin drivers
    // ***************************************************************
    // Only the first IO_PORTS ports have drivers; the rest are inputs.
    // The drive is registered so that a register write reaches the pads
    // on one edge for all bits of a port, without combinational glitches.
    // Peripheral outputs share pclk and need no synchroniser.
    always_comb
    begin
        pin_out_d = '0;
        pin_oe_d = '0;
        for (int i = 0; i < NIO; i++)
        begin
            logic val;
            logic drv;
            pin_cfg_t c;
            val = 1'b0;
            drv = 1'b0;
            c = '{latch: latch_q[i/PORT_W][i%PORT_W],
                  dir: dir_q[i/PORT_W][i%PORT_W],
                  fmode: fmode_q[i/PORT_W][i%PORT_W],
                  odrain: odrain_q[i/PORT_W][i%PORT_W]};
            if (c.fmode == `FMODE_ALT)
            begin
                val = alt_out[i];
                drv = alt_is_out[i];
            end
            else
            begin
                val = c.latch;
                drv = 1'b1;
            end
            if (c.dir == `DIR_INPUT)
                drv = 1'b0;
            if (c.odrain == `ODRAIN_ON && c.dir != `DIR_INPUT)
            begin
                pin_out_d[i] = 1'b0;
                pin_oe_d[i] = drv && !val;
            end
            else
            begin
                pin_out_d[i] = val;
                pin_oe_d[i] = drv;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pin_out_q <= '0;
            pin_oe_q <= '0;
        end
        else
        begin
            pin_out_q <= pin_out_d;
            pin_oe_q <= pin_oe_d;
        end
    end

    assign pin_out = pin_out_q;
    assign pin_oe = pin_oe_q;

    // Peripherals see which pins are handed over to them.
    always_comb
    begin
        alt_sel = '0;
        for (int i = 0; i < NPIN; i++)
            alt_sel[i] = fmode_q[i/PORT_W][i%PORT_W];
    end

endmodule : general_purpose_port_control

//--- testbench/port_sva.sv
`timescale 1ns/1ps
module port_sva
    import gpio_pkg::*;
#(
    parameter int PORT_W = 8,
    parameter int IO_PORTS = 14,
    parameter int IN_PORTS = 2
)
(
    input wire logic pclk, // Clock
    input wire logic presetn, // Reset
    input wire logic psel, // Select
    input wire logic penable, // Enable
    input wire logic pwrite, // Direction
    input wire logic [11:0] paddr, // Address
    input wire logic [31:0] pwdata, // Write data
    input wire logic [3:0] pstrb, // Strobes
    input wire logic pready, // Ready
    input wire logic [31:0] prdata, // Read data
    input wire logic pslverr, // Error
    input wire logic [IO_PORTS*PORT_W-1:0] pin_out, // Drive value
    input wire logic [IO_PORTS*PORT_W-1:0] pin_oe, // Drive enable
    input wire logic [(IO_PORTS+IN_PORTS)*PORT_W-1:0] alt_sel // Alt mode
);
    // ****
    // Properties
    // ****
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence wr_hit(logic [11:0] a);
        psel && penable && pwrite && pstrb[0] && paddr == a;
    endsequence

    ready_set_a: assert property (psel && penable |-> pready)
        else $error("ready missing in access phase");
    ready_idle_a: assert property (!psel |-> !pready && !pslverr)
        else $error("ready or error while idle");
    unmapped_err_a: assert property
        (psel && penable && paddr[11:8] != 4'h0 |-> pslverr)
        else $error("unmapped access not flagged");
    read_upper_a: assert property
        (psel && penable && !pwrite |-> prdata[31:8] == 24'h0)
        else $error("upper read bits not zero");
    dir_in_a: assert property
        (wr_hit(12'h004) ##0 pwdata[0] |-> ##2 !pin_oe[0])
        else $error("input pin still driven");
    latch_drive_a: assert property
        (wr_hit(12'h000) ##2 (pin_oe[0] && !alt_sel[0])
        |-> pin_out[0] == $past(pwdata[0], 2))
        else $error("pin does not follow latch");
    mode_sel_a: assert property
        (wr_hit(12'h008) |-> ##2 alt_sel[0] == $past(pwdata[0], 2))
        else $error("mode bit not applied");
    reset_idle_a: assert property
        ($rose(presetn) |-> pin_oe == '0 && pin_out == '0)
        else $error("pins driven after reset");
endmodule : port_sva

//--- testbench/pin_partner.sv
`timescale 1ns/1ps
module pin_partner
(
    input wire logic [111:0] pin_out, // Drive value
    input wire logic [111:0] pin_oe, // Drive enable
    input wire logic [127:0] ext, // External device level
    output logic [127:0] pin_in // Resolved pin level
);
    always_comb
    begin
        pin_in = ext;
        for (int i = 0; i < 112; i++)
        begin
            if (pin_oe[i])
            begin
                pin_in[i] = pin_out[i];
            end
        end
    end
endmodule : pin_partner

//--- testbench/test_general_purpose_port_control.sv
`timescale 1ns/1ps
module test_general_purpose_port_control;
    typedef struct packed {
        logic [7:0] dir, mode, latch, ext, fo, fio, rd, oe, out;
    } row_t;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [3:0] pstrb;
    logic [127:0] pin_in, ext, alt_in;
    logic [111:0] pin_out, pin_oe, alt_out, alt_is_out;
    int n_errors = 0;
    int tests_run = 0;
    row_t rows [3] = '{
        '{8'hF0, 8'hCC, 8'hAA, 8'h3C, 8'h0F, 8'h08, 8'h3A, 8'h0B, 8'h0A},
        '{8'h00, 8'h0F, 8'h33, 8'hFF, 8'h05, 8'h0C, 8'h37, 8'hFC, 8'h34},
        '{8'hFF, 8'h00, 8'h00, 8'hC3, 8'h00, 8'h00, 8'hC3, 8'h00, 8'h00}};

    general_purpose_port_control i_dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe(pin_oe), .alt_out(alt_out), .alt_is_out(alt_is_out),
        .alt_in(alt_in), .alt_sel());
    pin_partner i_pins (.pin_out(pin_out), .pin_oe(pin_oe), .ext(ext),
        .pin_in(pin_in));

    // ****
    // Tasks
    // ****
    task automatic summarize;
        if (n_errors == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : summarize

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
            n_errors++;
        end
    endtask : chk

    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [7:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        repeat (2) @(posedge pclk);
    endtask : apb

    task automatic rd(input logic [11:0] a, input logic [7:0] exp);
        apb(1'b0, a, 8'h00);
        chk(r[7:0], exp);
    endtask : rd

    // ****
    // Stimulus
    // ****
    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    initial
    begin
        repeat (20000) @(posedge pclk);
        n_errors++;
        summarize;
    end

    initial
    begin
        {psel, penable, pwrite, paddr, pwdata, presetn} = '0;
        pstrb = 4'hF;
        ext = '0;
        alt_out = '0;
        alt_is_out = '0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        rd(12'h004, 8'hFF);
        rd(12'h008, 8'h00);
        rd(12'h000, 8'h00);
        rd(12'h00C, 8'h00);
        foreach (rows[i])
        begin
            ext[7:0] <= rows[i].ext;
            alt_out[7:0] <= rows[i].fo;
            alt_is_out[7:0] <= rows[i].fio;
            apb(1'b1, 12'h008, rows[i].mode);
            apb(1'b1, 12'h004, rows[i].dir);
            apb(1'b1, 12'h000, rows[i].latch);
            rd(12'h000, rows[i].rd);
            chk(pin_oe[7:0], rows[i].oe);
            chk(pin_out[7:0] & pin_oe[7:0], rows[i].out);
        end
        apb(1'b1, 12'h000, 8'h55);
        chk(pin_oe[7:0], 8'h00);
        apb(1'b1, 12'h008, 8'hFF);
        apb(1'b1, 12'h008, 8'h00);
        apb(1'b1, 12'h004, 8'h00);
        rd(12'h000, 8'h55);
        chk(pin_out[7:0], 8'h55);
        apb(1'b1, 12'h00C, 8'h01);
        apb(1'b1, 12'h000, 8'h54);
        chk({6'h0, pin_oe[0], pin_out[0]}, 8'h02);
        apb(1'b1, 12'h004, 8'h01);
        chk({7'h0, pin_oe[0]}, 8'h00);
        ext[119:112] <= 8'hA5;
        apb(1'b1, 12'h0E4, 8'h00);
        rd(12'h0E4, 8'hFF);
        rd(12'h0E0, 8'hA5);
        chk(alt_in[119:112], 8'hA5);
        apb(1'b0, 12'h100, 8'h00);
        chk({7'h0, e}, 8'h01);
        chk(r[7:0], 8'h00);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        chk(pin_oe[7:0], 8'h00);
        presetn <= 1'b1;
        rd(12'h004, 8'hFF);
        rd(12'h00C, 8'h00);
        apb(1'b1, 12'h004, 8'h00);
        rd(12'h000, 8'h00);
        summarize;
    end
endmodule : test_general_purpose_port_control

bind general_purpose_port_control port_sva #(.PORT_W(PORT_W),
    .IO_PORTS(IO_PORTS), .IN_PORTS(IN_PORTS)) u_sva (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .pin_out(pin_out),
    .pin_oe(pin_oe), .alt_sel(alt_sel));
